// File: logic/emb_pkg.sv
// Constants and types shared by the external memory bus interface.
// Assumes one clk period stands for one oscillator period of the bus timing.
package emb_pkg;

  localparam int unsigned CNT_W = 4;

  // Oscillator period equals the 50 MHz clock period.
  localparam int unsigned OSC_PERIOD_NS = 20;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam logic [CNT_W-1:0] PERIOD_CYC = CNT_W'(OSC_PERIOD_NS / CLK_PERIOD_NS);

  // Slot lengths in oscillator periods.
  localparam logic [CNT_W-1:0] SLOT_LAST      = CNT_W'(6 * PERIOD_CYC - 1);
  localparam logic [CNT_W-1:0] DATA_SLOT_LAST = CNT_W'(12 * PERIOD_CYC - 1);

  // Phase positions within a slot.
  localparam logic [CNT_W-1:0] ALE_LEN     = CNT_W'(2 * PERIOD_CYC);
  localparam logic [CNT_W-1:0] FETCH_START = CNT_W'(3 * PERIOD_CYC);
  localparam logic [CNT_W-1:0] STB_START   = CNT_W'(5 * PERIOD_CYC);
  localparam logic [CNT_W-1:0] STB_END     = CNT_W'(11 * PERIOD_CYC - 1);

  localparam logic [16:0] ROM_BYTES = 17'h01000;

  localparam logic [CNT_W-1:0] CNT_RESET  = 4'h0;
  localparam logic [7:0]       BYTE_RESET = 8'h00;

  typedef enum logic [1:0] {
    SLOT_IDLE  = 2'b00,
    SLOT_FETCH = 2'b01,
    SLOT_DATA  = 2'b10
  } emb_slot_e;

endpackage

// File: logic/emb_slot_timer.sv
// Period counter that paces the bus slots.
// Assumes the caller says whether the running slot is a long data slot.
`timescale 1ns/1ps
module emb_slot_timer #(
  parameter int unsigned CNT_W = emb_pkg::CNT_W
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             long_slot,
  output logic      [CNT_W-1:0] cnt_ff,
  output logic      [CNT_W-1:0] nxt_cnt,
  output logic                  slot_end
);

  logic [CNT_W-1:0] last;

  assign last     = long_slot ? emb_pkg::DATA_SLOT_LAST : emb_pkg::SLOT_LAST;
  assign slot_end = (cnt_ff == last);
  assign nxt_cnt  = slot_end ? emb_pkg::CNT_RESET : CNT_W'(cnt_ff + 1'b1);

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff <= emb_pkg::CNT_RESET;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule // emb_slot_timer

// File: logic/emb_bus_ctrl.sv
// External memory bus controller: fetch and data cycles over a multiplexed bus.
// Assumes requests are synchronous to clk and external memory meets the strobe timing.
//
// Operation
// RQ1 - Fetch strobe pulses each six-period slot when fetching externally, not in data cycles.
// RQ2 - Fetch strobe stays high while code runs from on-chip memory.
// RQ3 - Address latch strobe pulses each six periods, omitted inside data cycles.
// RQ4 - External latch captures the low address byte on the latch strobe.
// RQ5 - Select high: on-chip fetch below 4096, external fetch above.
// RQ6 - Select low: every fetch goes to external program memory.
// RQ7 - High address byte is driven on the high port during external cycles.
// RQ8 - Low port carries the low address byte, then the data byte.
// RQ9 - External program memory drives the bus only while fetch strobe is low.
// RQ10 - Write strobe on alternate bit six; memory latches the low port byte.
// RQ11 - Read strobe on alternate bit seven; memory drives the low port.
// RQ12 - Read and write strobes work only when their port latch bit is one.
// RQ13 - A high level on the reset pin resets the block.
// RQ14 - Address, then latch strobe falls, then fetch strobe, released by next latch.
// RQ15 - Data strobe starts three periods after latch falls, lasts six periods.
`timescale 1ns/1ps
module emb_bus_ctrl #(
  parameter int unsigned ADDR_W = 16
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              reset_standby_pin,
  input  wire logic              external_access_select_n,
  input  wire logic              alt_wr_latch,
  input  wire logic              alt_rd_latch,
  input  wire logic              fetch_req,
  input  wire logic [ADDR_W-1:0] program_counter,
  input  wire logic              xdata_req,
  input  wire logic              xdata_we,
  input  wire logic [ADDR_W-1:0] xdata_addr,
  input  wire logic [7:0]        xdata_wdata,
  input  wire logic [7:0]        low_addr_data_port_in,
  output logic      [7:0]        low_addr_data_port_out,
  output logic                   low_addr_data_port_oe_n,
  output logic      [7:0]        high_addr_port,
  output logic                   address_latch_strobe,
  output logic                   program_fetch_strobe_n,
  output logic                   data_write_strobe_n,
  output logic                   data_read_strobe_n,
  output logic                   fetch_taken,
  output logic                   fetch_done,
  output logic                   fetch_from_rom,
  output logic      [7:0]        instr_byte,
  output logic                   xdata_taken,
  output logic                   xdata_done,
  output logic      [7:0]        xdata_rdata
);

  localparam int unsigned CW = emb_pkg::CNT_W;

  ////////////////////////////////////////////////////////////////////////////////
  // Slot sequencing

  logic                  rst;
  logic [CW-1:0]         cnt_ff;
  logic [CW-1:0]         nxt_cnt;
  logic                  slot_end;
  emb_pkg::emb_slot_e    state_ff;
  emb_pkg::emb_slot_e    nxt_state;
  logic                  ext_ff;
  logic                  nxt_ext;
  logic                  we_ff;
  logic                  nxt_we;
  logic [ADDR_W-1:0]     addr_ff;
  logic [ADDR_W-1:0]     nxt_addr;
  logic [7:0]            wdata_ff;
  logic [7:0]            nxt_wdata;
  logic                  take_data;
  logic                  take_fetch;
  logic                  fetch_ext_sel;

  assign rst = !reset_n || reset_standby_pin; // RQ13

  emb_slot_timer #(.CNT_W(CW)) u_timer (
    .clk       (clk),
    .rst       (rst),
    .long_slot (state_ff == emb_pkg::SLOT_DATA),
    .cnt_ff    (cnt_ff),
    .nxt_cnt   (nxt_cnt),
    .slot_end  (slot_end)
  );

  // Data requests win a slot boundary over fetches.
  assign take_data  = slot_end && xdata_req;
  assign take_fetch = slot_end && !xdata_req && fetch_req;

  // Fetches below the on-chip size go internal only when the select pin is high.
  assign fetch_ext_sel = !external_access_select_n || // RQ6
                         ({1'b0, program_counter} >= emb_pkg::ROM_BYTES); // RQ5

  assign nxt_state = take_data  ? emb_pkg::SLOT_DATA  :
                     take_fetch ? emb_pkg::SLOT_FETCH :
                     slot_end   ? emb_pkg::SLOT_IDLE  : state_ff;
  assign nxt_ext   = take_fetch ? fetch_ext_sel : (take_data ? 1'b1 : ext_ff);
  assign nxt_we    = take_data  ? xdata_we : we_ff;
  assign nxt_addr  = take_data  ? xdata_addr : (take_fetch ? program_counter : addr_ff);
  assign nxt_wdata = take_data  ? xdata_wdata : wdata_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= emb_pkg::SLOT_IDLE;
      ext_ff   <= 1'b0;
      we_ff    <= 1'b0;
      addr_ff  <= '0;
      wdata_ff <= emb_pkg::BYTE_RESET;
    end else begin
      state_ff <= nxt_state;
      ext_ff   <= nxt_ext;
      we_ff    <= nxt_we;
      addr_ff  <= nxt_addr;
      wdata_ff <= nxt_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin decode, looked ahead one cycle so the pins line up with cnt_ff

  logic       d_ext_cycle;
  logic       d_ale;
  logic       d_fetch;
  logic       d_strobe;
  logic       d_drive_addr;
  logic       d_drive_data;
  logic       fetch_act_ff;
  logic       strobe_ff;
  logic       fetch_end;
  logic       data_end;
  logic       ale_ff;
  logic       program_fetch_strobe_n_n_ff;
  logic       wr_n_ff;
  logic       rd_n_ff;
  logic [7:0] lo_ff;
  logic       lo_oe_n_ff;
  logic [7:0] hi_ff;

  assign d_ext_cycle  = (nxt_state == emb_pkg::SLOT_DATA) ||
                        ((nxt_state == emb_pkg::SLOT_FETCH) && nxt_ext);
  assign d_ale        = nxt_cnt < emb_pkg::ALE_LEN; // RQ3
  assign d_fetch      = (nxt_state == emb_pkg::SLOT_FETCH) &&
                        (nxt_cnt >= emb_pkg::FETCH_START); // RQ14
  assign d_strobe     = (nxt_state == emb_pkg::SLOT_DATA) &&
                        (nxt_cnt >= emb_pkg::STB_START) && (nxt_cnt <= emb_pkg::STB_END); // RQ15
  assign d_drive_addr = d_ext_cycle && d_ale;
  assign d_drive_data = (nxt_state == emb_pkg::SLOT_DATA) && nxt_we && !d_ale;
  assign fetch_end    = fetch_act_ff && !d_fetch;
  assign data_end     = strobe_ff && !d_strobe;

  always_ff @(posedge clk) begin
    if (rst) begin
      fetch_act_ff <= 1'b0;
      strobe_ff    <= 1'b0;
      ale_ff       <= 1'b0;
      program_fetch_strobe_n_n_ff    <= 1'b1;
      wr_n_ff      <= 1'b1;
      rd_n_ff      <= 1'b1;
      lo_ff        <= emb_pkg::BYTE_RESET;
      lo_oe_n_ff   <= 1'b1;
      hi_ff        <= emb_pkg::BYTE_RESET;
    end else begin
      fetch_act_ff <= d_fetch;
      strobe_ff    <= d_strobe;
      ale_ff       <= d_ale;
      program_fetch_strobe_n_n_ff    <= !(d_fetch && nxt_ext); // RQ1 RQ2
      wr_n_ff      <= !(d_strobe && nxt_we && alt_wr_latch); // RQ10 RQ12
      rd_n_ff      <= !(d_strobe && !nxt_we && alt_rd_latch); // RQ11 RQ12
      lo_ff        <= d_drive_data ? nxt_wdata : nxt_addr[7:0]; // RQ8
      lo_oe_n_ff   <= !(d_drive_addr || d_drive_data); // RQ8
      hi_ff        <= d_ext_cycle ? nxt_addr[15:8] : hi_ff; // RQ7
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Request handshakes and captured bytes

  logic       fetch_taken_ff;
  logic       xdata_taken_ff;
  logic       fetch_done_ff;
  logic       xdata_done_ff;
  logic       from_rom_ff;
  logic [7:0] instr_ff;
  logic [7:0] rdata_ff;

  // Bytes are sampled on the edge where the strobe rises, while memory still drives.
  always_ff @(posedge clk) begin
    if (rst) begin
      fetch_taken_ff <= 1'b0;
      xdata_taken_ff <= 1'b0;
      fetch_done_ff  <= 1'b0;
      xdata_done_ff  <= 1'b0;
      from_rom_ff    <= 1'b0;
      instr_ff       <= emb_pkg::BYTE_RESET;
      rdata_ff       <= emb_pkg::BYTE_RESET;
    end else begin
      fetch_taken_ff <= take_fetch;
      xdata_taken_ff <= take_data;
      fetch_done_ff  <= fetch_end;
      xdata_done_ff  <= data_end;
      from_rom_ff    <= fetch_end ? !ext_ff : from_rom_ff;
      instr_ff       <= (fetch_end && ext_ff) ? low_addr_data_port_in : instr_ff; // RQ9
      rdata_ff       <= (data_end && !we_ff) ? low_addr_data_port_in : rdata_ff; // RQ11
    end
  end

  assign low_addr_data_port_out  = lo_ff;
  assign low_addr_data_port_oe_n = lo_oe_n_ff;
  assign high_addr_port          = hi_ff;
  assign address_latch_strobe    = ale_ff; // RQ4
  assign program_fetch_strobe_n  = program_fetch_strobe_n_n_ff;
  assign data_write_strobe_n     = wr_n_ff;
  assign data_read_strobe_n      = rd_n_ff;
  assign fetch_taken             = fetch_taken_ff;
  assign fetch_done              = fetch_done_ff;
  assign fetch_from_rom          = from_rom_ff;
  assign instr_byte              = instr_ff;
  assign xdata_taken             = xdata_taken_ff;
  assign xdata_done              = xdata_done_ff;
  assign xdata_rdata             = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_ale_fetch_period: assert property ( // RQ3
    $rose(ale_ff) && (state_ff == emb_pkg::SLOT_FETCH) |-> ##6 $rose(ale_ff))
    else $error("latch strobe not repeated after six periods");
  a_ale_data_gap: assert property ( // RQ3
    $rose(ale_ff) && (state_ff == emb_pkg::SLOT_DATA) |-> ##2 (!ale_ff)[*8])
    else $error("latch strobe pulsed inside a data cycle");
  a_program_fetch_strobe_n_width: assert property ( // RQ1
    $fell(program_fetch_strobe_n_n_ff) |-> (!program_fetch_strobe_n_n_ff)[*3] ##1 program_fetch_strobe_n_n_ff)
    else $error("fetch strobe width is not three periods");
  a_program_fetch_strobe_n_data_idle: assert property ( // RQ1
    (state_ff == emb_pkg::SLOT_DATA) |-> program_fetch_strobe_n_n_ff)
    else $error("fetch strobe active in a data cycle");
  a_program_fetch_strobe_n_internal: assert property ( // RQ2
    (state_ff == emb_pkg::SLOT_FETCH) && !ext_ff |-> program_fetch_strobe_n_n_ff)
    else $error("fetch strobe active during on-chip fetch");
  a_select_internal: assert property ( // RQ5
    take_fetch && external_access_select_n && (program_counter < 16'h1000)
      |=> !ext_ff ##[1:6] fetch_done_ff && fetch_from_rom)
    else $error("low fetch with select high did not stay on chip");
  a_select_external: assert property ( // RQ6
    take_fetch && !external_access_select_n |=> ##3 !program_fetch_strobe_n_n_ff)
    else $error("fetch with select low did not go external");
  a_high_addr: assert property ( // RQ7
    take_data |=> high_addr_port == $past(xdata_addr[15:8]))
    else $error("high address byte wrong in data cycle");
  a_low_addr: assert property ( // RQ8
    take_fetch && fetch_ext_sel |=> !lo_oe_n_ff && (lo_ff == $past(program_counter[7:0]))
      ##2 lo_oe_n_ff)
    else $error("low port did not carry then release the low address");
  a_program_fetch_strobe_n_after_ale: assert property ( // RQ14
    $fell(program_fetch_strobe_n_n_ff) |-> !ale_ff && !$past(ale_ff) && lo_oe_n_ff)
    else $error("fetch strobe asserted before latch strobe fell");
  a_strobe_delay: assert property ( // RQ15
    $fell(ale_ff) && (state_ff == emb_pkg::SLOT_DATA) |-> ##3 $rose(strobe_ff)
      ##0 strobe_ff[*6] ##1 !strobe_ff)
    else $error("data strobe delay or width wrong");
  a_wr_gate: assert property ( // RQ12
    !wr_n_ff |-> $past(alt_wr_latch) && strobe_ff && we_ff)
    else $error("write strobe without its port latch bit");
  a_wr_data: assert property ( // RQ10
    !wr_n_ff |-> !lo_oe_n_ff && (lo_ff == wdata_ff))
    else $error("write strobe without write data on the low port");
  a_rd_release: assert property ( // RQ11
    !rd_n_ff |-> lo_oe_n_ff)
    else $error("low port driven during read strobe");
  a_reset_pin: assert property (@(posedge clk) disable iff (!reset_n) // RQ13
    reset_standby_pin |=> !ale_ff && program_fetch_strobe_n_n_ff && wr_n_ff && rd_n_ff && lo_oe_n_ff)
    else $error("reset pin did not reset the bus");

  c_ext_fetch: cover property (fetch_done_ff && !from_rom_ff);
  c_int_fetch: cover property (fetch_done_ff && from_rom_ff);
  c_data_read: cover property (xdata_done_ff && !we_ff);
  c_data_write: cover property ($rose(wr_n_ff));

endmodule // emb_bus_ctrl

// File: sim/emb_ext_mem.sv
// Behavioural external program and data memory with its address latch.
// Assumes the bench resolves the shared low port from this model and the controller.
`timescale 1ns/1ps
module emb_ext_mem (
  input  wire logic       clk,
  input  wire logic       ale,
  input  wire logic [7:0] low_port,
  input  wire logic [7:0] high_port,
  input  wire logic       program_fetch_strobe_n_n,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  output logic            mem_drive,
  output logic      [7:0] mem_data
);
  logic [7:0] lat_ff;
  logic [7:0] xmem [0:255];

  // Memory starts cleared so a read of a byte never written has a known value.
  initial begin
    for (int k = 0; k < 256; k++) begin
      xmem[k] = 8'h00;
    end
  end

  always @(posedge clk) begin
    if (ale) lat_ff <= low_port;
    if (!wr_n) xmem[lat_ff] <= low_port;
  end

  // Code bytes are a fixed pattern of the full address, so a wrong high byte shows up.
  assign mem_drive = !program_fetch_strobe_n_n || !rd_n;
  assign mem_data  = !program_fetch_strobe_n_n ? (lat_ff ^ high_port ^ 8'ha5) : xmem[lat_ff];
endmodule // emb_ext_mem

// File: sim/testbench.sv
// Self-checking bench for the external memory bus controller.
// Assumes emb_ext_mem sits on the far side of the multiplexed bus.
`timescale 1ns/1ps
module testbench;
  logic        clk, reset_n, rst_pin, ea_n, wl, rl, f_req, x_req, x_we;
  logic [15:0] pc, x_addr, a;
  logic [7:0]  x_wd, wd, lo_out, bus, last_bus, mem_data, instr, rdata;
  logic [7:0]  shadow [0:255];
  logic        oe_n, ale, program_fetch_strobe_n_n, wr_n, rd_n, mem_drive;
  logic        f_tk, f_dn, f_rom, x_tk, x_dn;
  logic [7:0]  hi;
  int          fail_count, samples_checked, seed, i, al, ps;

  emb_bus_ctrl dut (.clk(clk), .reset_n(reset_n), .reset_standby_pin(rst_pin),
    .external_access_select_n(ea_n), .alt_wr_latch(wl), .alt_rd_latch(rl),
    .fetch_req(f_req), .program_counter(pc), .xdata_req(x_req), .xdata_we(x_we),
    .xdata_addr(x_addr), .xdata_wdata(x_wd), .low_addr_data_port_in(bus),
    .low_addr_data_port_out(lo_out), .low_addr_data_port_oe_n(oe_n),
    .high_addr_port(hi), .address_latch_strobe(ale), .program_fetch_strobe_n(program_fetch_strobe_n_n),
    .data_write_strobe_n(wr_n), .data_read_strobe_n(rd_n), .fetch_taken(f_tk),
    .fetch_done(f_dn), .fetch_from_rom(f_rom), .instr_byte(instr), .xdata_taken(x_tk),
    .xdata_done(x_dn), .xdata_rdata(rdata));

  emb_ext_mem mem (.clk(clk), .ale(ale), .low_port(bus), .high_port(hi), .program_fetch_strobe_n_n(program_fetch_strobe_n_n),
    .rd_n(rd_n), .wr_n(wr_n), .mem_drive(mem_drive), .mem_data(mem_data));

  // A released bus shows the inverse of its last level so stale data cannot pass.
  assign bus = !oe_n ? lo_out : (mem_drive ? mem_data : ~last_bus);
  always @(posedge clk) last_bus <= bus;

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic test_done;
    if (fail_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Code byte that the memory model holds at a full fetch address.
  function automatic logic [7:0] exp_code(input logic [15:0] ad);
    return ad[7:0] ^ ad[15:8] ^ 8'ha5;
  endfunction

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // One fetch (d=0) or data access (d=1), counting strobe cycles from taken to done.
  task automatic op(input logic d, input logic we, input logic [15:0] ad, input logic [7:0] dv);
    int n, ac, pl, rdl, wrl, ov;
    logic ext;
    n = 0; ac = 0; pl = 0; rdl = 0; wrl = 0; ov = 0;
    ext = d || !(ea_n && ad < 16'h1000);
    f_req = !d; x_req = d; x_we = we; pc = ad; x_addr = ad; x_wd = dv;
    do begin
      @(negedge clk);
      n++;
    end while (!(d ? x_tk : f_tk) && n < 40);
    if (n >= 40) begin
      fail_count++;
      test_done();
    end
    f_req = 1'b0; x_req = 1'b0;
    if (ext) chk("address out", ad, {hi, lo_out});
    chk("drive enable", {15'h0, !ext}, {15'h0, oe_n});
    while (!(d ? x_dn : f_dn) && n < 80) begin
      ac += ale; pl += !program_fetch_strobe_n_n; rdl += !rd_n; wrl += !wr_n; ov += ale && !program_fetch_strobe_n_n;
      @(negedge clk);
      n++;
    end
    if (n >= 80) begin
      fail_count++;
      test_done();
    end
    chk("ale cycles", 16'd2, 16'(ac));
    chk("fetch strobe overlap", 16'd0, 16'(ov));
    if (d) begin
      chk("fetch strobe in data", 16'd0, 16'(pl));
      chk("write strobe cycles", (we && wl) ? 16'd6 : 16'd0, 16'(wrl));
      chk("read strobe cycles", (!we && rl) ? 16'd6 : 16'd0, 16'(rdl));
      if (we && wl) shadow[ad[7:0]] = dv;
      if (!we && rl) chk("read data", {8'h0, shadow[ad[7:0]]}, {8'h0, rdata});
    end else begin
      chk("on-chip flag", {15'h0, !ext}, {15'h0, f_rom});
      chk("fetch strobe cycles", ext ? 16'd3 : 16'd0, 16'(pl));
      if (ext) chk("instr", {8'h0, exp_code(ad)}, {8'h0, instr});
    end
  endtask

  initial begin
    seed = 74; fail_count = 0; samples_checked = 0; last_bus = 8'h00;
    reset_n = 1'b0; rst_pin = 1'b0; ea_n = 1'b1; wl = 1'b1; rl = 1'b1;
    f_req = 1'b0; x_req = 1'b0; x_we = 1'b0; pc = 16'h0; x_addr = 16'h0; x_wd = 8'h00;
    for (i = 0; i < 256; i++) begin
      shadow[i] = 8'h00;
    end
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    op(1'b0, 1'b0, 16'h0fff, 8'h00);
    op(1'b0, 1'b0, 16'h1000, 8'h00);
    ea_n = 1'b0;
    op(1'b0, 1'b0, 16'h0000, 8'h00);
    op(1'b1, 1'b1, 16'h00ff, 8'hff);
    op(1'b1, 1'b0, 16'h00ff, 8'h00);
    for (i = 0; i < 60; i++) begin
      ea_n = 1'($random(seed));
      a = 16'($random(seed));
      wd = 8'($random(seed));
      wl = ($random(seed) & 3) != 0;
      rl = ($random(seed) & 3) != 0;
      op(1'b0, 1'b0, a, 8'h00);
      op(1'b1, 1'b1, a, wd);
      op(1'b1, 1'b0, a, 8'h00);
    end
    wl = 1'b1;
    x_req = 1'b1; x_we = 1'b1; x_addr = 16'h3377;
    repeat (9) @(negedge clk);
    rst_pin = 1'b1; x_req = 1'b0;
    repeat (2) @(negedge clk);
    chk("reset strobes", 16'h000f, {11'h0, ale, program_fetch_strobe_n_n, wr_n, rd_n, oe_n});
    rst_pin = 1'b0;
    repeat (2) @(negedge clk);
    al = 0;
    ps = 0;
    repeat (12) begin
      @(negedge clk);
      al += ale;
      ps += !program_fetch_strobe_n_n;
    end
    chk("idle ale cycles", 16'd4, 16'(al));
    chk("idle fetch strobe cycles", 16'd0, 16'(ps));
    test_done();
  end
endmodule // testbench
